// ---- dv/plm_chk.sv ----
// Concurrent checks on the register bus and interrupt of the measurement unit.
`timescale 1ns/1ps
module plm_chk
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic irq,
    input wire logic measure_done_output,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped early");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped early");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_blat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
    a_blat: assert property (p_blat) else $error("write answer late");
    property p_wblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wblk: assert property (p_wblk) else $error("write taken while answer pending");
    property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rblk: assert property (p_rblk) else $error("read taken while answer pending");
    property p_r16; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_r16: assert property (p_r16) else $error("read data wider than 16 bits");
    property p_irqclr; $fell(irq) && $past(aresetn) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
    a_irqclr: assert property (p_irqclr) else $error("interrupt fell without a write");
    c_rd: cover property (s_axi_arvalid && s_axi_arready);
    c_irq: cover property ($rose(irq));
    c_done: cover property ($rose(measure_done_output));
endmodule : plm_chk
bind plm_top plm_chk u_chk (.*);

// ---- dv/plm_src.sv ----
// Source model of the measured pin.
`timescale 1ns/1ps
module plm_src
(
    input wire logic aclk,
    output logic pin
);
    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    initial pin = 1'h0;
    task lvl(input logic v);
        @(posedge aclk);
        pin <= v;
    endtask : lvl
    task pulse(input logic v, input int n);
        lvl(v);
        repeat (n) @(posedge aclk);
        pin <= ~v;
    endtask : pulse
endmodule : plm_src

// ---- dv/pulse_length_measure_tb.sv ----
// Self-checking bench for the pulse length measurement unit.
`timescale 1ns/1ps
module pulse_length_measure_tb;
    // ------------------------------------------------------------
    // Signals, instances and bus tasks
    // ------------------------------------------------------------
    logic aclk = 1'h0, aresetn = 1'h0, measure_gate_input = 1'h1, count_gate_input = 1'h0;
    logic measure_input, measure_done_output, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
    int errors = 0, compares = 0, cyc = 0;
    always #5 aclk = ~aclk;
    plm_src u_src (.aclk(aclk), .pin(measure_input));
    plm_top u_dut (.*);
    always @(posedge aclk)
        if (++cyc == 20000) results(1);
    task results(input int extra);
        errors += extra;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    task chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        @(posedge aclk iff s_axi_arready);
        s_axi_arvalid <= 1'h0;
        @(posedge aclk iff s_axi_rvalid);
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rd
    task wdone;
        rdat = 32'h0000_0000;
        repeat (400) if (rdat[1] !== 1'h1) rd(plm_pkg::OFS_STATUS);
        chk(16'(rdat[1]), 16'h0001);
    endtask : wdone
    task t_regs;
        rd(plm_pkg::OFS_CFG);
        chk(rdat[15:0], 16'h0000);
        wr(plm_pkg::OFS_RELOAD, 16'hFFFF);
        rd(plm_pkg::OFS_RELOAD);
        chk(rdat[15:0], 16'hFFFF);
        rd(8'h1C);
        chk(16'(rrsp), 16'h0002);
        $display("t_regs end");
    endtask : t_regs
    task t_manual;
        count_gate_input <= 1'h1;
        wr(plm_pkg::OFS_RELOAD, 16'h0001);
        wr(plm_pkg::OFS_CMD, 16'h0001);
        u_src.pulse(1'h1, 1100);
        wdone();
        chk(16'(measure_done_output), 16'h0001);
        rd(plm_pkg::OFS_RESULT);
        chk(rdat[15:0], 16'h0005);
        u_src.pulse(1'h1, 300);
        repeat (20) @(posedge aclk);
        rd(plm_pkg::OFS_STATUS);
        chk(16'(rdat[1:0]), 16'h0000);
        $display("t_manual end");
    endtask : t_manual
    task t_auto;
        u_src.lvl(1'h1);
        wr(plm_pkg::OFS_RELOAD, 16'h0000);
        wr(plm_pkg::OFS_CFG, 16'h3013);
        wr(plm_pkg::OFS_CMD, 16'h0001);
        repeat (4) @(posedge aclk);
        chk(16'(measure_done_output), 16'h0001);
        u_src.pulse(1'h0, 550);
        wdone();
        chk(16'(measure_done_output), 16'h0000);
        rd(plm_pkg::OFS_RESULT);
        chk(rdat[15:0], 16'h0005);
        u_src.pulse(1'h0, 350);
        wdone();
        rd(plm_pkg::OFS_RESULT);
        chk(rdat[15:0], 16'h0003);
        $display("t_auto end");
    endtask : t_auto
    task t_abort;
        wr(plm_pkg::OFS_IRQ_MASK, 16'h0002);
        u_src.lvl(1'h0);
        repeat (200) @(posedge aclk);
        wr(plm_pkg::OFS_CMD, 16'h0002);
        repeat (3) @(posedge aclk);
        chk(16'(irq), 16'h0001);
        rd(plm_pkg::OFS_STATUS);
        chk(16'(rdat[3:0] & 4'hB), 16'h0008);
        wr(plm_pkg::OFS_IRQ_STAT, 16'h0003);
        repeat (3) @(posedge aclk);
        chk(16'(irq), 16'h0000);
        u_src.lvl(1'h1);
        u_src.pulse(1'h0, 300);
        repeat (20) @(posedge aclk);
        rd(plm_pkg::OFS_STATUS);
        chk(16'(rdat[1:0]), 16'h0000);
        $display("t_abort end");
    endtask : t_abort
    task t_gate;
        wr(plm_pkg::OFS_CMD, 16'h0001);
        u_src.lvl(1'h0);
        repeat (200) @(posedge aclk);
        rd(plm_pkg::OFS_STATUS);
        chk(16'(rdat[0]), 16'h0001);
        measure_gate_input <= 1'h0;
        repeat (10) @(posedge aclk);
        rd(plm_pkg::OFS_IRQ_STAT);
        chk(16'(rdat[1:0]), 16'h0002);
        rd(plm_pkg::OFS_STATUS);
        chk(16'(rdat[0]), 16'h0000);
        measure_gate_input <= 1'h1;
        $display("t_gate end");
    endtask : t_gate
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_manual();
        t_auto();
        t_abort();
        t_gate();
        results(0);
    end
endmodule : pulse_length_measure_tb

// ---- logic/plm_pkg.sv ----
// Constants, register map and types shared by the pulse length measurement unit.
package plm_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_DIV = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DONE_PULSE_NS = 1000;
    localparam int DONE_PULSE_CYC = (DONE_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : DONE_PULSE_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_RELOAD = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CFG_W = 14;
    localparam int CFG_IN_LSB = 0;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_GATE_LSB = 8;
    localparam int CFG_DONE_LSB = 12;
    localparam logic [2:0] MODE_MANUAL = 3'h0;
    localparam logic [2:0] MODE_AUTO = 3'h1;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_ABORT_BIT = 1;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_VALID_BIT = 2;
    localparam int STAT_INVALID_BIT = 3;
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_INVALID_BIT = 1;
    localparam logic [CFG_W-1:0] CFG_RST = 14'h0000;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Measurement states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARM = 3'b010,
        ST_MEAS = 3'b100
    } plm_state_t;

endpackage : plm_pkg

// ---- logic/plm_sync.sv ----
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module plm_sync
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_in,
    output logic pin_out
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // The output follows only when the second and third stages agree.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            pin_out <= 1'b0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                pin_out <= s3_r;
        end
    end

endmodule : plm_sync

// ---- logic/plm_timebase.sv ----
// Time base: 1 us prescaler and reloadable divider producing time base pulses.
`timescale 1ns/1ps
module plm_timebase
#(
    parameter int CNT_W = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic restart,
    input wire logic [CNT_W-1:0] reload,
    output logic tb_pulse
);

    localparam int PRE_W = $clog2(plm_pkg::TICK_DIV);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(plm_pkg::TICK_DIV - 1);

    logic [PRE_W-1:0] pre_r;
    logic [CNT_W-1:0] cnt_r;
    logic tick_w;
    logic wrap_w;

    assign tick_w = (pre_r == PRE_LAST);
    assign wrap_w = tick_w && (cnt_r == reload);

    // [RQ1] 1 us tick
    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart || tick_w)
            pre_r <= '0;
        else
            pre_r <= pre_r + 1'b1;
    end

    // [RQ2] Divide by reload+1
    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart || wrap_w)
            cnt_r <= '0;
        else if (tick_w)
            cnt_r <= cnt_r + 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart)
            tb_pulse <= 1'b0;
        else
            tb_pulse <= wrap_w;
    end

endmodule : plm_timebase

// ---- logic/plm_top.sv ----
// Pulse length measurement unit with AXI4-Lite register access.
`timescale 1ns/1ps

// Summary of operation
// [RQ1] A 16-bit time base counter runs from a 1 us tick.
// [RQ2] The time base divides that tick by reload plus one.
// [RQ3] Normal polarity counts time base pulses while the input is high.
// [RQ4] Input configuration selects counter and measure polarity; values 2 and 3 count low.
// [RQ5] Mode 1 measures pulse after pulse after one start command.
// [RQ6] Mode 0 measures one pulse; the host starts again for each further one.
// [RQ7] The result is an unsigned 16-bit count, saturating at 65535.
// [RQ8] Gate configuration: static-normal, static-inverted, dynamic-normal, dynamic-inverted.
// [RQ9] Done output configuration: static-normal, static-inverted, dynamic-normal, dynamic-inverted.
// [RQ10] The done output activates at the end of every completed measurement.
// [RQ11] A pollable done flag tells the host the result may be read.
// [RQ12] The result register returns the unscaled count of time base pulses.
// [RQ13] Abort stops a measurement and invalidates it; only start resumes.
// [RQ14] Losing the gate invalidates the measurement; only start resumes.
// [RQ15] The count gate input has no effect on measurement.
// [RQ16] The first active level after start clears the counter and restarts the time base.
module plm_top
#(
    parameter int CNT_W = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic measure_input,
    input wire logic measure_gate_input,
    input wire logic count_gate_input,
    output logic measure_done_output,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam int DP_W = $clog2(plm_pkg::DONE_PULSE_CYC + 1);
    localparam logic [DP_W-1:0] DP_LOAD = DP_W'(plm_pkg::DONE_PULSE_CYC);

    // ------------------------------------------------------------------
    // Byte lane merge
    // ------------------------------------------------------------------
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction : lane_merge

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] wr_addr_r;
    logic [31:0] wr_data_r;
    logic [3:0] wr_strb_r;
    logic [plm_pkg::CFG_W-1:0] cfg_r;
    logic [CNT_W-1:0] reload_r;
    logic [plm_pkg::IRQ_W-1:0] irq_stat_r;
    logic [plm_pkg::IRQ_W-1:0] irq_stat_nxt;
    logic [plm_pkg::IRQ_W-1:0] irq_mask_r;
    plm_pkg::plm_state_t st_r;
    plm_pkg::plm_state_t st_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] result_r;
    logic done_flag_r;
    logic done_flag_nxt;
    logic valid_r;
    logic invalid_r;
    logic gate_arm_r;
    logic gate_prev_r;
    logic done_act_r;
    logic [DP_W-1:0] dp_cnt_r;
    logic meas_sync;
    logic gate_sync;
    logic tb_pulse;

    // ------------------------------------------------------------------
    // Decode and selection
    // ------------------------------------------------------------------
    wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire wsel_cfg = (wr_addr_r == plm_pkg::OFS_CFG);
    wire wsel_reload = (wr_addr_r == plm_pkg::OFS_RELOAD);
    wire wsel_cmd = (wr_addr_r == plm_pkg::OFS_CMD);
    wire wsel_istat = (wr_addr_r == plm_pkg::OFS_IRQ_STAT);
    wire wsel_imask = (wr_addr_r == plm_pkg::OFS_IRQ_MASK);
    wire wsel_status = (wr_addr_r == plm_pkg::OFS_STATUS);
    wire wsel_result = (wr_addr_r == plm_pkg::OFS_RESULT);
    wire wr_mapped = wsel_cfg || wsel_reload || wsel_cmd || wsel_istat || wsel_imask || wsel_status || wsel_result;
    wire cmd_start = wr_fire && wsel_cmd && wr_strb_r[0] && wr_data_r[plm_pkg::CMD_START_BIT];
    wire cmd_abort = wr_fire && wsel_cmd && wr_strb_r[0] && wr_data_r[plm_pkg::CMD_ABORT_BIT];
    wire [31:0] cfg_merge = lane_merge(32'(cfg_r), wr_data_r, wr_strb_r);
    wire [31:0] reload_merge = lane_merge(32'(reload_r), wr_data_r, wr_strb_r);
    wire [31:0] imask_merge = lane_merge(32'(irq_mask_r), wr_data_r, wr_strb_r);
    wire [plm_pkg::IRQ_W-1:0] irq_w1c = (wr_fire && wsel_istat && wr_strb_r[0])
                                        ? wr_data_r[plm_pkg::IRQ_W-1:0] : '0;

    wire rsel_cfg = (s_axi_araddr == plm_pkg::OFS_CFG);
    wire rsel_reload = (s_axi_araddr == plm_pkg::OFS_RELOAD);
    wire rsel_cmd = (s_axi_araddr == plm_pkg::OFS_CMD);
    wire rsel_status = (s_axi_araddr == plm_pkg::OFS_STATUS);
    wire rsel_result = (s_axi_araddr == plm_pkg::OFS_RESULT);
    wire rsel_istat = (s_axi_araddr == plm_pkg::OFS_IRQ_STAT);
    wire rsel_imask = (s_axi_araddr == plm_pkg::OFS_IRQ_MASK);
    wire rd_mapped = rsel_cfg || rsel_reload || rsel_cmd || rsel_status || rsel_result || rsel_istat || rsel_imask;
    // [RQ11] Pollable status
    wire [31:0] status_word = 32'({invalid_r, valid_r, done_flag_r, (st_r != plm_pkg::ST_IDLE)});
    // [RQ12] Raw unscaled count
    wire [31:0] rd_word = rsel_cfg ? 32'(cfg_r) :
                          rsel_reload ? 32'(reload_r) :
                          rsel_status ? status_word :
                          rsel_result ? 32'(result_r) :
                          rsel_istat ? 32'(irq_stat_r) :
                          rsel_imask ? 32'(irq_mask_r) : 32'h0000_0000;
    wire rd_result = ar_hs && rsel_result;

    // Configuration fields.
    wire [1:0] in_cfg = cfg_r[plm_pkg::CFG_IN_LSB +: 2];
    wire [2:0] mode_cfg = cfg_r[plm_pkg::CFG_MODE_LSB +: 3];
    wire [1:0] gate_cfg = cfg_r[plm_pkg::CFG_GATE_LSB +: 2];
    wire [1:0] done_cfg = cfg_r[plm_pkg::CFG_DONE_LSB +: 2];

    // [RQ3] Measured level; [RQ4] bit 1 of the input field inverts it.
    wire meas_act = meas_sync ^ in_cfg[1];
    // [RQ8] Gate: bit 0 inverts, bit 1 selects edge-armed behaviour.
    wire gate_lvl = gate_sync ^ gate_cfg[0];
    wire gate_ok = gate_cfg[1] ? gate_arm_r : gate_lvl;
    // [RQ14] Gate loss while running
    wire gate_lost = (st_r != plm_pkg::ST_IDLE) && !gate_ok;
    // [RQ13] Abort or gate loss ends the run as invalid.
    wire run_kill = (st_r != plm_pkg::ST_IDLE) && (cmd_abort || gate_lost);
    // [RQ16] Counter clear and time base restart at first active level.
    wire begin_meas = (st_r == plm_pkg::ST_ARM) && !run_kill && !cmd_start && gate_ok && meas_act;
    wire finish = (st_r == plm_pkg::ST_MEAS) && !run_kill && !cmd_start && !meas_act;

    // ------------------------------------------------------------------
    // Input synchronisers and time base
    // ------------------------------------------------------------------
    plm_sync u_meas_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(measure_input),
        .pin_out(meas_sync)
    );

    plm_sync u_gate_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(measure_gate_input),
        .pin_out(gate_sync)
    );

    // [RQ15] The count gate input is deliberately left unused here.
    wire unused_count_gate = count_gate_input;

    plm_timebase #(
        .CNT_W(CNT_W)
    ) u_timebase
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(begin_meas),
        .reload(reload_r),
        .tb_pulse(tb_pulse)
    );

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= plm_pkg::RESP_OKAY;
            wr_addr_r <= 8'h00;
            wr_data_r <= 32'h0000_0000;
            wr_strb_r <= 4'h0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr_r <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data_r <= s_axi_wdata;
                wr_strb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? plm_pkg::RESP_OKAY : plm_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= plm_pkg::RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? plm_pkg::RESP_OKAY : plm_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_r <= plm_pkg::CFG_RST;
            reload_r <= plm_pkg::RELOAD_RST;
            irq_mask_r <= plm_pkg::IRQ_MASK_RST;
        end
        else if (wr_fire)
        begin
            if (wsel_cfg)
                cfg_r <= cfg_merge[plm_pkg::CFG_W-1:0];
            // [RQ2] Reload value 0 to 65535
            if (wsel_reload)
                reload_r <= reload_merge[CNT_W-1:0];
            if (wsel_imask)
                irq_mask_r <= imask_merge[plm_pkg::IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Measurement state machine
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            plm_pkg::ST_IDLE:
                if (cmd_start && !cmd_abort)
                    st_nxt = plm_pkg::ST_ARM;
            plm_pkg::ST_ARM:
                if (run_kill)
                    st_nxt = plm_pkg::ST_IDLE;
                else if (begin_meas)
                    st_nxt = plm_pkg::ST_MEAS;
            plm_pkg::ST_MEAS:
                if (run_kill)
                    st_nxt = plm_pkg::ST_IDLE;
                else if (cmd_start)
                    st_nxt = plm_pkg::ST_ARM;
                // [RQ5] Automatic mode re-arms
                else if (finish && mode_cfg == plm_pkg::MODE_AUTO)
                    st_nxt = plm_pkg::ST_ARM;
                // [RQ6] Manual mode stops after one pulse
                else if (finish)
                    st_nxt = plm_pkg::ST_IDLE;
            default:
                st_nxt = plm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_r <= plm_pkg::ST_IDLE;
        else
            st_r <= st_nxt;
    end

    // [RQ7] Saturating 16-bit counter of time base pulses
    always_ff @(posedge aclk)
    begin
        if (!aresetn || begin_meas)
            cnt_r <= '0;
        else if (st_r == plm_pkg::ST_MEAS && tb_pulse && cnt_r != CNT_MAX)
            cnt_r <= cnt_r + 1'b1;
    end

    // Result capture and validity.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            result_r <= '0;
            valid_r <= 1'b0;
            invalid_r <= 1'b0;
        end
        else if (run_kill)
        begin
            valid_r <= 1'b0;
            invalid_r <= 1'b1;
        end
        else if (finish)
        begin
            result_r <= cnt_r;
            valid_r <= 1'b1;
        end
        else if (cmd_start)
        begin
            valid_r <= 1'b0;
            invalid_r <= 1'b0;
        end
    end

    // [RQ11] Done flag: set wins over clear by result read; start blocks the set and clears.
    assign done_flag_nxt = finish || (done_flag_r && !(cmd_start || rd_result));

    // [RQ8] Edge-armed gate capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            done_flag_r <= 1'b0;
            gate_prev_r <= 1'b0;
            gate_arm_r <= 1'b0;
        end
        else
        begin
            done_flag_r <= done_flag_nxt;
            gate_prev_r <= gate_lvl;
            if (cmd_abort)
                gate_arm_r <= 1'b0;
            else if (gate_lvl && !gate_prev_r)
                gate_arm_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Done output
    // ------------------------------------------------------------------
    // [RQ10] Activate at each completion; [RQ9] static holds, dynamic pulses.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            done_act_r <= 1'b0;
            dp_cnt_r <= '0;
        end
        else if (finish)
        begin
            done_act_r <= 1'b1;
            dp_cnt_r <= done_cfg[1] ? DP_LOAD : '0;
        end
        else if (done_cfg[1])
        begin
            if (dp_cnt_r != '0)
                dp_cnt_r <= dp_cnt_r - 1'b1;
            done_act_r <= (dp_cnt_r > DP_W'(1));
        end
        else if (cmd_start || run_kill)
            done_act_r <= 1'b0;
    end

    // [RQ9] Output polarity
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            measure_done_output <= 1'b0;
        else
            measure_done_output <= done_act_r ^ done_cfg[0];
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign irq_stat_nxt = {run_kill, finish} | (irq_stat_r & ~irq_w1c);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_r <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_r <= irq_stat_nxt;
            irq <= |(irq_stat_nxt & irq_mask_r);
        end
    end

endmodule : plm_top
